/* File: src/adc_host_end.sv */
// Bus controller end: APB registers drive write, read and sync cycles
`timescale 1ns/1ps
module adc_host_end (
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic        clk_en_in,
  adc_pins_if.host_mp      pins,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             irq_out
);
  import adc_port_pkg::*;

  localparam int SYN_W = DATA_W + 3;

  host_state_t       state_reg;
  logic [3:0]        cnt_reg;
  logic [SYN_W-1:0]  synced;
  logic              rdy_s;
  logic              standby_indicator_n_s;
  logic              sync_s;
  logic              rdy_d_reg;
  logic              apb_acc;
  logic              apb_wr;
  logic              mapped;
  logic              busy;
  logic              wr_req_reg;
  logic              rd_req_reg;
  logic              pulse_req_reg;
  logic              is_read_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              sync_drv_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_mask_reg;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_stat_next;
  logic              cs_n_reg;
  logic              rd_n_reg;
  logic              wr_n_reg;
  logic              d_oe_reg;
  logic              sync_pin_reg;

  pin_sync2 #(
    .WIDTH(SYN_W)
  ) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .clk_en_in  (clk_en_in),
    .d_in       ({pins.rdy_n, pins.standby_indicator_n, pins.sync_bus,
                  pins.d_bus}),
    .rst_val_in ({2'h3, 1'b0, {DATA_W{1'b0}}}),
    .q_out      (synced)
  );
  assign rdy_s   = synced[DATA_W+2];
  assign standby_indicator_n_s = synced[DATA_W+1];
  assign sync_s  = synced[DATA_W];

  assign apb_acc = psel_in && penable_in;
  assign apb_wr  = apb_acc && pready_out && pwrite_in;
  assign busy    = (state_reg != H_IDLE) || wr_req_reg || rd_req_reg ||
                   pulse_req_reg;
  assign mapped  = paddr_in == REG_WDATA || paddr_in == REG_CTRL ||
                   paddr_in == REG_RDATA || paddr_in == REG_STATUS ||
                   paddr_in == REG_IRQ_STAT || paddr_in == REG_IRQ_MASK;

  // One wait state lets read data come from a flop
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else if (clk_en_in) begin
      pready_out  <= apb_acc && !pready_out;
      pslverr_out <= apb_acc && !pready_out && !mapped;
      prdata_out  <= 32'h0000_0000;
      if (apb_acc && !pready_out && !pwrite_in) begin
        case (paddr_in)
          REG_WDATA:    prdata_out <= {19'h0, wdata_reg};
          REG_CTRL:     prdata_out <= {31'h0, sync_drv_reg};
          REG_RDATA:    prdata_out <= {19'h0, rdata_reg};
          REG_STATUS:   prdata_out <= {28'h0, sync_s, standby_indicator_n_s, rdy_s, busy};
          REG_IRQ_STAT: prdata_out <= {29'h0, irq_stat_reg};
          REG_IRQ_MASK: prdata_out <= {29'h0, irq_mask_reg};
          default:      prdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // New requests are refused while one is still pending or running
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wdata_reg     <= {DATA_W{1'b0}};
      sync_drv_reg  <= 1'b0;
      irq_mask_reg  <= {IRQ_W{1'b0}};
      wr_req_reg    <= 1'b0;
      rd_req_reg    <= 1'b0;
      pulse_req_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (state_reg == H_IDLE) begin
        wr_req_reg    <= 1'b0;
        rd_req_reg    <= 1'b0;
        pulse_req_reg <= 1'b0;
      end
      if (apb_wr && paddr_in == REG_WDATA && !busy) begin
        wdata_reg  <= pwdata_in[DATA_W-1:0];
        wr_req_reg <= 1'b1;
      end
      if (apb_wr && paddr_in == REG_CTRL) begin
        sync_drv_reg <= pwdata_in[CTRL_SYNC_DRV];
        if (!busy) begin
          rd_req_reg    <= pwdata_in[CTRL_READ];
          pulse_req_reg <= pwdata_in[CTRL_PULSE];
        end
      end
      if (apb_wr && paddr_in == REG_IRQ_MASK) begin
        irq_mask_reg <= pwdata_in[IRQ_W-1:0];
      end
    end
  end

  // Select falls a cycle before the strobe and rises well after it,
  // covering the far end's synchroniser delay
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state_reg    <= H_IDLE;
      cnt_reg      <= 4'h0;
      is_read_reg  <= 1'b0;
      cs_n_reg     <= 1'b1;
      rd_n_reg     <= 1'b1;
      wr_n_reg     <= 1'b1;
      d_oe_reg     <= 1'b0;
      sync_pin_reg <= 1'b0;
      rdata_reg    <= {DATA_W{1'b0}};
    end else if (clk_en_in) begin
      case (state_reg)
        H_IDLE: begin
          if (wr_req_reg || rd_req_reg) begin
            is_read_reg <= !wr_req_reg;
            cs_n_reg    <= 1'b0;
            d_oe_reg    <= wr_req_reg;
            state_reg   <= H_SETUP;
          end else if (pulse_req_reg) begin
            sync_pin_reg <= 1'b1;
            cnt_reg      <= SYNC_HIGH_CYC;
            state_reg    <= H_SYNC;
          end
        end
        H_SETUP: begin
          rd_n_reg  <= !is_read_reg;
          wr_n_reg  <= is_read_reg;
          cnt_reg   <= is_read_reg ? RD_LOW_CYC : WR_LOW_CYC;
          state_reg <= H_STROBE;
        end
        H_STROBE: begin
          if (cnt_reg == 4'h1) begin
            if (is_read_reg) begin
              rdata_reg <= synced[DATA_W-1:0];
            end
            rd_n_reg  <= 1'b1;
            wr_n_reg  <= 1'b1;
            cnt_reg   <= HOLD_CYC;
            state_reg <= H_RECOVER;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        H_RECOVER: begin
          if (cnt_reg == 4'h1) begin
            cs_n_reg  <= 1'b1;
            d_oe_reg  <= 1'b0;
            state_reg <= H_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        H_SYNC: begin
          if (cnt_reg == 4'h1) begin
            sync_pin_reg <= 1'b0;
            state_reg    <= H_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  assign irq_set[IRQ_WR_DONE] = state_reg == H_RECOVER && cnt_reg == 4'h1 &&
                                !is_read_reg;
  assign irq_set[IRQ_RD_DONE] = state_reg == H_RECOVER && cnt_reg == 4'h1 &&
                                is_read_reg;
  assign irq_set[IRQ_RDY]     = rdy_d_reg && !rdy_s;

  // A set in the clearing cycle wins
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (apb_wr && paddr_in == REG_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~pwdata_in[IRQ_W-1:0];
    end
    irq_stat_next = irq_stat_next | irq_set;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdy_d_reg    <= 1'b1;
      irq_stat_reg <= {IRQ_W{1'b0}};
      irq_out      <= 1'b0;
    end else if (clk_en_in) begin
      rdy_d_reg    <= rdy_s;
      irq_stat_reg <= irq_stat_next;
      irq_out      <= |(irq_stat_next & irq_mask_reg);
    end
  end

  assign pins.cs_n         = cs_n_reg;
  assign pins.rd_n         = rd_n_reg;
  assign pins.wr_n         = wr_n_reg;
  assign pins.host_d       = wdata_reg;
  assign pins.host_d_oe    = d_oe_reg;
  assign pins.host_sync    = sync_pin_reg;
  assign pins.host_sync_oe = sync_drv_reg;
endmodule

/* File: src/adc_port_pkg.sv */
// Shared constants and types for the converter host port and its controller
package adc_port_pkg;
  // Data bus and configuration word
  localparam int          DATA_W        = 13;
  localparam int          BYTE_W        = 8;
  localparam int          HI_W          = DATA_W - BYTE_W;
  localparam logic [12:0] CFG_RESET     = 13'h0100;
  localparam int          CFG_UBS_BIT   = 7;
  localparam int          CFG_SYNC_BIT  = 8;
  localparam int          CFG_CMD_LSB   = 9;
  localparam int          CFG_CMD_W     = 3;
  localparam int          CFG_BW_BIT    = 12;
  localparam logic [2:0]  CMD_STANDBY   = 3'h0;

  // Clock figures
  localparam int          CLK_PERIOD_NS = 50;
  localparam int          EXT_CLK_MIN_KHZ = 50;
  localparam int          EXT_CLK_MAX_KHZ = 12000;

  // Device: cycles after reset release before the strap is trusted
  localparam logic [1:0]  STRAP_SETTLE  = 2'h2;

  // Controller strobe timing in cycles
  localparam logic [3:0]  WR_LOW_CYC    = 4'h6;
  localparam logic [3:0]  RD_LOW_CYC    = 4'h8;
  localparam logic [3:0]  HOLD_CYC      = 4'h4;
  localparam logic [3:0]  SYNC_HIGH_CYC = 4'h4;

  // Controller register offsets
  localparam logic [7:0]  REG_WDATA     = 8'h00;
  localparam logic [7:0]  REG_CTRL      = 8'h04;
  localparam logic [7:0]  REG_RDATA     = 8'h08;
  localparam logic [7:0]  REG_STATUS    = 8'h0C;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h10;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h14;

  // Control and status bit positions
  localparam int          CTRL_SYNC_DRV = 0;
  localparam int          CTRL_READ     = 1;
  localparam int          CTRL_PULSE    = 2;
  localparam int          IRQ_WR_DONE   = 0;
  localparam int          IRQ_RD_DONE   = 1;
  localparam int          IRQ_RDY       = 2;
  localparam int          IRQ_W         = 3;

  typedef enum logic [4:0] {
    H_IDLE    = 5'h01,
    H_SETUP   = 5'h02,
    H_STROBE  = 5'h04,
    H_RECOVER = 5'h08,
    H_SYNC    = 5'h10
  } host_state_t;
endpackage

/* File: src/adc_pins_if.sv */
// Pin-level link between the converter port and its bus controller
`timescale 1ns/1ps
interface adc_pins_if;
  import adc_port_pkg::*;
  logic              cs_n;
  logic              rd_n;
  logic              wr_n;
  logic [DATA_W-1:0] host_d;
  logic              host_d_oe;
  logic [DATA_W-1:0] dev_d;
  logic [DATA_W-1:0] dev_d_oe;
  logic              host_sync;
  logic              host_sync_oe;
  logic              dev_sync;
  logic              dev_sync_oe;
  logic              write_edge_select;
  logic              rdy_n;
  logic              standby_indicator_n;
  logic [DATA_W-1:0] d_bus;
  logic              sync_bus;

  // Undriven data lines float high through a board pull-up; an undriven sync line reads low
  genvar i;
  for (i = 0; i < DATA_W; i++) begin : g_bit
    assign d_bus[i] = dev_d_oe[i] ? dev_d[i] :
                      (host_d_oe ? host_d[i] : 1'b1);
  end
  assign sync_bus = dev_sync_oe ? dev_sync :
                    (host_sync_oe ? host_sync : 1'b0);

  modport device_mp (
    input  cs_n, rd_n, wr_n, d_bus, sync_bus, write_edge_select,
    output dev_d, dev_d_oe, dev_sync, dev_sync_oe, rdy_n,
           standby_indicator_n
  );
  modport host_mp (
    input  d_bus, sync_bus, rdy_n, standby_indicator_n,
    output cs_n, rd_n, wr_n, host_d, host_d_oe, host_sync, host_sync_oe
  );
endinterface

/* File: src/pin_sync2.sv */
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in,
  input  wire logic             srst_in,
  input  wire logic             clk_en_in,
  input  wire logic [WIDTH-1:0] d_in,
  input  wire logic [WIDTH-1:0] rst_val_in,
  output logic      [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      meta_reg <= rst_val_in;
      q_out    <= rst_val_in;
    end else if (clk_en_in) begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule

/* File: src/adc_device_end.sv */
// Converter end of the parallel host port: strobes, config word, sync pin
`timescale 1ns/1ps
module adc_device_end (
  input  wire logic                       ref_clk_in,
  input  wire logic                       srst_in,
  input  wire logic                       clk_en_in,
  adc_pins_if.device_mp                   pins,
  input  wire logic [adc_port_pkg::DATA_W-1:0] result_in,
  input  wire logic                       conv_done_in,
  output logic                            conv_start_out,
  output logic                            cmd_write_out,
  output logic [adc_port_pkg::DATA_W-1:0] config_out
);
  import adc_port_pkg::*;

  localparam int SYN_W = DATA_W + 5;

  logic [SYN_W-1:0]  raw_pins;
  logic [SYN_W-1:0]  synced;
  logic [SYN_W-1:0]  sync_rst_val;
  logic              cs_s;
  logic              rd_s;
  logic              wr_s;
  logic              sync_s;
  logic              strap_s;
  logic [DATA_W-1:0] dat_s;

  logic              wr_act;
  logic              rd_act;
  logic              wr_act_d_reg;
  logic              rd_act_d_reg;
  logic              sync_d_reg;
  logic [1:0]        strap_cnt_reg;
  logic              strap_done_reg;
  logic              edge_sel_reg;
  logic [DATA_W-1:0] dat_hold_reg;
  logic              wr_evt;
  logic [DATA_W-1:0] wr_word;
  logic [DATA_W-1:0] cfg_reg;
  logic [DATA_W-1:0] cfg_next;
  logic              standby;
  logic              busy_reg;
  logic              start_evt;
  logic              sync_rise;
  logic [DATA_W-1:0] result_reg;
  logic              hi_byte_reg;
  logic [DATA_W-1:0] dev_d_reg;
  logic [DATA_W-1:0] dev_d_oe_reg;
  logic              sync_oe_reg;
  logic              rdy_n_reg;
  logic              standby_indicator_n_n_reg;

  // Strobes idle high after reset so no false edge is seen
  assign raw_pins     = {pins.cs_n, pins.rd_n, pins.wr_n, pins.sync_bus,
                         pins.write_edge_select, pins.d_bus};
  assign sync_rst_val = {3'h7, 2'h0, {DATA_W{1'b0}}};

  pin_sync2 #(
    .WIDTH(SYN_W)
  ) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .clk_en_in  (clk_en_in),
    .d_in       (raw_pins),
    .rst_val_in (sync_rst_val),
    .q_out      (synced)
  );

  assign cs_s    = synced[DATA_W+4];
  assign rd_s    = synced[DATA_W+3];
  assign wr_s    = synced[DATA_W+2];
  assign sync_s  = synced[DATA_W+1];
  assign strap_s = synced[DATA_W];
  assign dat_s   = synced[DATA_W-1:0];

  // Select gates both directions
  assign wr_act = !cs_s && !wr_s;
  assign rd_act = !cs_s && !rd_s;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      wr_act_d_reg <= 1'b0;
      rd_act_d_reg <= 1'b0;
      sync_d_reg   <= 1'b0;
    end else if (clk_en_in) begin
      wr_act_d_reg <= wr_act;
      rd_act_d_reg <= rd_act;
      sync_d_reg   <= sync_s;
    end
  end

  // Strap is caught once, after the synchroniser has settled;
  // later changes on the pin are ignored
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
      edge_sel_reg   <= 1'b0;
    end else if (clk_en_in && !strap_done_reg) begin
      if (strap_cnt_reg == STRAP_SETTLE) begin
        edge_sel_reg   <= strap_s;
        strap_done_reg <= 1'b1;
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
      end
    end
  end

  // Input buffers follow the bus only while a write is active
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      dat_hold_reg <= {DATA_W{1'b0}};
    end else if (clk_en_in && wr_act) begin
      dat_hold_reg <= dat_s;
    end
  end

  // Falling mode takes the word at the strobe's start, rising mode the
  // last word seen before the strobe released
  assign wr_evt  = strap_done_reg &&
                   (edge_sel_reg ? (wr_act && !wr_act_d_reg)
                                 : (!wr_act && wr_act_d_reg));
  assign wr_word = edge_sel_reg ? dat_s : dat_hold_reg;

  always_comb begin
    cfg_next = cfg_reg;
    if (wr_evt) begin
      if (cfg_reg[CFG_BW_BIT]) begin
        cfg_next = wr_word;
      end else if (cfg_reg[CFG_UBS_BIT]) begin
        cfg_next[DATA_W-1:BYTE_W] = wr_word[HI_W-1:0];
        cfg_next[CFG_UBS_BIT]     = 1'b0;
      end else begin
        cfg_next[BYTE_W-1:0] = wr_word[BYTE_W-1:0];
      end
    end
  end

  // Config is write-only: no path leads it onto the data bus
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cfg_reg       <= CFG_RESET;
      config_out    <= CFG_RESET;
      cmd_write_out <= 1'b0;
    end else if (clk_en_in) begin
      cfg_reg       <= cfg_next;
      config_out    <= cfg_next;
      cmd_write_out <= wr_evt;
    end
  end

  // Indicator follows the newly written command, so a wake request
  // shows at once rather than when the core wakes
  assign standby = cfg_reg[CFG_CMD_LSB +: CFG_CMD_W] == CMD_STANDBY;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      standby_indicator_n_n_reg <= 1'b0;
    end else if (clk_en_in) begin
      standby_indicator_n_n_reg <= cfg_next[CFG_CMD_LSB +: CFG_CMD_W] != CMD_STANDBY;
    end
  end

  // Sync edges during a conversion are dropped; free-running in
  // output mode
  assign sync_rise = sync_s && !sync_d_reg;
  assign start_evt = strap_done_reg && !standby && !busy_reg &&
                     (cfg_reg[CFG_SYNC_BIT] ? sync_rise : 1'b1);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      busy_reg       <= 1'b0;
      conv_start_out <= 1'b0;
    end else if (clk_en_in) begin
      conv_start_out <= start_evt;
      if (start_evt) begin
        busy_reg <= 1'b1;
      end else if (conv_done_in) begin
        busy_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sync_oe_reg <= 1'b0;
    end else if (clk_en_in) begin
      sync_oe_reg <= !cfg_next[CFG_SYNC_BIT];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdy_n_reg <= 1'b1;
    end else if (clk_en_in) begin
      rdy_n_reg <= !(wr_evt || (busy_reg && conv_done_in));
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      result_reg <= {DATA_W{1'b0}};
    end else if (clk_en_in && busy_reg && conv_done_in) begin
      result_reg <= result_in;
    end
  end

  // In byte mode reads alternate low byte, then high byte
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      hi_byte_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (cfg_reg[CFG_BW_BIT]) begin
        hi_byte_reg <= 1'b0;
      end else if (!rd_act && rd_act_d_reg) begin
        hi_byte_reg <= !hi_byte_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      dev_d_reg    <= {DATA_W{1'b0}};
      dev_d_oe_reg <= {DATA_W{1'b0}};
    end else if (clk_en_in) begin
      if (cfg_reg[CFG_BW_BIT] || !hi_byte_reg) begin
        dev_d_reg <= result_reg;
      end else begin
        dev_d_reg <= {{BYTE_W{1'b0}}, result_reg[DATA_W-1:BYTE_W]};
      end
      dev_d_oe_reg[BYTE_W-1:0]      <= {BYTE_W{rd_act}};
      dev_d_oe_reg[DATA_W-1:BYTE_W] <=
        {HI_W{rd_act && cfg_reg[CFG_BW_BIT]}};
    end
  end

  assign pins.dev_d               = dev_d_reg;
  assign pins.dev_d_oe            = dev_d_oe_reg;
  assign pins.dev_sync            = busy_reg;
  assign pins.dev_sync_oe         = sync_oe_reg;
  assign pins.rdy_n               = rdy_n_reg;
  assign pins.standby_indicator_n = standby_indicator_n_n_reg;
endmodule

/* File: testbench/adc_pins_props.sv */
// Pin-level checks on the link between converter port and controller
`timescale 1ns/1ps
module adc_pins_props (
  input wire logic        ref_clk_in,
  input wire logic        srst_in,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [12:0] dev_d_oe,
  input wire logic        dev_sync,
  input wire logic        dev_sync_oe,
  input wire logic        rdy_n,
  input wire logic        write_edge_select,
  input wire logic        standby_indicator_n
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  a_oe_under_cs: assert property (|dev_d_oe |-> !cs_n)
    else $error("data driven without select");
  a_oe_needs_rd: assert property ($rose(|dev_d_oe) |-> !rd_n)
    else $error("data drive began without read");
  a_oe_off_cs_up: assert property (
    $rose(cs_n) |-> dev_d_oe == 13'h0000)
    else $error("data still driven at select release");
  a_no_oe_write: assert property (!wr_n |-> dev_d_oe == 13'h0000)
    else $error("data driven during write");
  a_oe_width: assert property (
    dev_d_oe inside {13'h0000, 13'h00FF, 13'h1FFF})
    else $error("bad data enable pattern");
  a_select_pair: assert property (
    !rd_n || !wr_n |-> !cs_n && (rd_n || wr_n))
    else $error("strobe without select");
  // The strap decides which strobe edge draws the ready pulse
  a_write_ready: assert property (
    $rose(wr_n) && !cs_n && !write_edge_select |-> ##[2:6] !rdy_n)
    else $error("write not answered by ready");
  a_fall_ready: assert property (
    $fell(wr_n) && !cs_n && write_edge_select |-> ##[2:6] !rdy_n)
    else $error("falling write not answered by ready");
  a_ready_pulse: assert property ($fell(rdy_n) |-> ##[1:2] rdy_n)
    else $error("ready held low too long");
  a_conv_end_rdy: assert property (
    $fell(dev_sync) && dev_sync_oe && $past(dev_sync_oe)
      |-> ##[0:2] !rdy_n)
    else $error("conversion end without ready");
  a_standby_write: assert property (
    $changed(standby_indicator_n)
      |-> !rdy_n || !$past(rdy_n) || !$past(rdy_n, 2))
    else $error("standby changed without write");
endmodule

/* File: testbench/adc_host_bus_and_sync_pins_test.sv */
// Bench joining both ends of the converter host port
`timescale 1ns/1ps
module adc_host_bus_and_sync_pins_test;
  import adc_port_pkg::*;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        perr, conv_done, conv_start, cmd_wr;
  logic [12:0] cfg;
  logic [3:0]  busy_cnt;
  int          errors, n_checks, n_starts, s, n_wr;
  localparam logic [12:0] RES = 13'h1A5C;

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end

  adc_pins_if pins ();
  adc_device_end u_adc_device_end (.ref_clk_in(clk), .srst_in(srst),
    .clk_en_in(1'b1), .pins(pins), .result_in(RES),
    .conv_done_in(conv_done), .conv_start_out(conv_start),
    .cmd_write_out(cmd_wr), .config_out(cfg));
  adc_host_end u_adc_host_end (.ref_clk_in(clk), .srst_in(srst),
    .clk_en_in(1'b1), .pins(pins), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .irq_out(irq));
  adc_pins_props u_adc_pins_props (.ref_clk_in(clk), .srst_in(srst),
    .cs_n(pins.cs_n), .rd_n(pins.rd_n), .wr_n(pins.wr_n),
    .dev_d_oe(pins.dev_d_oe), .dev_sync(pins.dev_sync),
    .dev_sync_oe(pins.dev_sync_oe), .rdy_n(pins.rdy_n),
    .standby_indicator_n(pins.standby_indicator_n),
    .write_edge_select(pins.write_edge_select));

  always #25 clk = ~clk;

  // Core stand-in: each start is answered five cycles later; the core's
  // own conversion clock range is left to the host system
  always @(posedge clk) begin
    conv_done <= (busy_cnt == 4'h1);
    if (cmd_wr === 1'b1) begin
      n_wr <= n_wr + 1;
    end
    if (conv_start === 1'b1) begin
      busy_cnt <= 4'h5;
      n_starts <= n_starts + 1;
    end else if (busy_cnt != 4'h0) begin
      busy_cnt <= busy_cnt - 4'h1;
    end
  end

  task automatic test_done;
    if (errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Values before the edge are read, so pready is sampled as APB intends
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_idle;
    do apb(1'b0, REG_STATUS, 32'h0); while (rdat[0] !== 1'b0);
  endtask

  // Eight-bit mode: low byte with upper select set, then upper bits
  task automatic cfg8(input logic [4:0] hi, input logic [6:0] lo);
    apb(1'b1, REG_WDATA, {24'h0, 1'b1, lo});
    wait_idle;
    `CHK("upper select", 1'b1, cfg[7])
    apb(1'b1, REG_WDATA, {27'h0, hi});
    wait_idle;
    `CHK("config", {hi, 1'b0, lo}, cfg)
  endtask

  task automatic t_reset_map;
    `CHK("config", CFG_RESET, cfg)
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK("status", 4'h2, rdat[3:0])
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped err", 1'b1, perr)
    `CHK("unmapped data", 32'h0, rdat)
  endtask

  task automatic t_async;
    cfg8(5'h12, 7'h00);
    `CHK("standby", 1'b1, pins.standby_indicator_n)
    s = n_starts;
    do @(posedge clk); while (conv_start !== 1'b1);
    @(posedge clk);
    @(posedge clk);
    `CHK("sync out", 1'b1, pins.sync_bus)
    repeat (20) @(posedge clk);
    `CHK("restarts", 1'b1, n_starts > s + 1)
    apb(1'b1, REG_CTRL, 32'h2);
    wait_idle;
    apb(1'b0, REG_RDATA, 32'h0);
    `CHK("read 13", RES, rdat[12:0])
  endtask

  task automatic t_byte_read;
    apb(1'b1, REG_WDATA, 32'h0300);
    wait_idle;
    `CHK("config", 13'h0300, cfg)
    repeat (10) @(posedge clk);
    apb(1'b1, REG_CTRL, 32'h2);
    wait_idle;
    apb(1'b0, REG_RDATA, 32'h0);
    // Undriven upper lines read back at the pull-up level
    `CHK("low byte", {5'h1F, RES[7:0]}, rdat[12:0])
    apb(1'b1, REG_CTRL, 32'h2);
    wait_idle;
    apb(1'b0, REG_RDATA, 32'h0);
    `CHK("high byte", {5'h1F, 3'h0, RES[12:8]}, rdat[12:0])
  endtask

  task automatic t_sync_in;
    s = n_starts;
    apb(1'b1, REG_CTRL, 32'h5);
    wait_idle;
    repeat (10) @(posedge clk);
    `CHK("sync starts", s + 1, n_starts)
    apb(1'b1, REG_CTRL, 32'h0);
  endtask

  task automatic t_irq_standby;
    apb(1'b1, REG_IRQ_MASK, 32'h1);
    @(posedge clk);
    `CHK("irq set", 1'b1, irq)
    apb(1'b1, REG_IRQ_STAT, 32'h1);
    @(posedge clk);
    `CHK("irq clear", 1'b0, irq)
    cfg8(5'h01, 7'h00);
    `CHK("standby", 1'b0, pins.standby_indicator_n)
  endtask

  // Strap high through a fresh reset selects the falling write edge
  task automatic t_fall_edge;
    srst                   <= 1'b1;
    pins.write_edge_select <= 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("config", CFG_RESET, cfg)
    s = n_wr;
    apb(1'b1, REG_WDATA, 32'h5A);
    wait_idle;
    `CHK("fall config", 13'h015A, cfg)
    `CHK("write pulses", s + 1, n_wr)
  endtask

  initial begin
    {clk, psel, penable, pwrite, conv_done} = '0;
    {paddr, pwdata, busy_cnt, errors, n_checks, n_starts, n_wr} = '0;
    srst = 1'b1;
    pins.write_edge_select = 1'b0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset_map;
    t_async;
    t_byte_read;
    t_sync_in;
    t_irq_standby;
    t_fall_edge;
    test_done;
  end

  // Whole sequence needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end
endmodule
